// *** rtl/gtb_params.svh ***
`ifndef GTB_PARAMS_SVH
`define GTB_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define GTB_CTRL_ADDR    16'hff48
`define GTB_AUXCTL_ADDR  16'hff46
`define GTB_AUX_ADDR     16'hfe46
`define GTB_CORE_ADDR    16'hfe48
`define GTB_CAPTURE_RELOAD_REG_ADDR  16'hfe4a

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define GTB_CTRL_RST     16'h0000
`define GTB_AUXCTL_RST   16'h0000
`define GTB_CNT_RST      16'h0000
`define GTB_CTRL_WMASK   16'hdfff
`define GTB_AUXCTL_WMASK 16'h3fff
`define GTB_OTL_BIT      10

// ----------------------------------------------------------------
// block prescaler terminal counts (divide minus one)
// ----------------------------------------------------------------
`define GTB_DIV_SEL00    4'h3
`define GTB_DIV_SEL01    4'h1
`define GTB_DIV_SEL10    4'hf
`define GTB_DIV_SEL11    4'h7

`endif

// *** rtl/gtb_pkg.sv ***
package gtb_pkg;

  typedef enum logic [2:0] {
    MODE_TIMER   = 3'b000,
    MODE_COUNTER = 3'b001,
    MODE_GATE_LO = 3'b010,
    MODE_GATE_HI = 3'b011
  } gtb_mode_t;

  typedef enum logic [1:0] {
    CAP_RISE  = 2'b00,
    CAP_FALL  = 2'b01,
    CAP_BOTH  = 2'b10,
    CAP_FIRST = 2'b11
  } gtb_cap_src_t;

  typedef struct packed {
    logic       reload_enable;
    logic       clear_on_capture;
    logic       rsvd;
    logic [1:0] block_prescaler_sel;
    logic       overflow_toggle_latch;
    logic       toggle_output_enable;
    logic       ext_direction_enable;
    logic       sw_direction;
    logic       run_bit;
    logic [2:0] mode_field;
    logic [2:0] input_select_field;
  } gtb_core_ctrl_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       aux_clear_on_capture;
    logic       capture_enable;
    logic [1:0] capture_src;
    logic       chain;
    logic       ext_direction_enable;
    logic       sw_direction;
    logic       run_bit;
    logic [2:0] mode_field;
    logic [2:0] input_select_field;
  } gtb_aux_ctrl_t;

  typedef struct packed {
    logic first_block_dir_input;
    logic first_block_count_input;
    logic capture_input_pin;
    logic aux_dir;
    logic aux_pin;
    logic core_dir;
    logic core_pin;
  } gtb_pins_t;

endpackage

// *** rtl/gtb_prescaler.sv ***
`include "gtb_params.svh"

module gtb_prescaler (
  input  wire logic       clk_i,    // module clock
  input  wire logic       rstn_i,   // sync reset, active low
  input  wire logic [1:0] sel_i,    // block prescaler select
  output logic            tick_o,   // basic clock enable pulse
  output logic [7:0]      phase_o   // basic ticks, free running
);

  logic [3:0] div;
  logic [3:0] limit;

  // non-linear select encoding
  always_comb begin
    case (sel_i)
      2'b00:   limit = `GTB_DIV_SEL00;
      2'b01:   limit = `GTB_DIV_SEL01;
      2'b10:   limit = `GTB_DIV_SEL10;
      default: limit = `GTB_DIV_SEL11;
    endcase
  end

  // >= so a select change never overshoots a full wrap
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div    <= 4'h0;
      tick_o <= 1'b0;
    end else if (div >= limit) begin
      div    <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      div    <= div + 4'h1;
      tick_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_o <= 8'h00;
    end else if (tick_o) begin
      phase_o <= phase_o + 8'h01;
    end
  end

endmodule

// *** rtl/gtb_sampler.sv ***
module gtb_sampler #(
  parameter int W = 7
) (
  input  wire logic         clk_i,   // module clock
  input  wire logic         rstn_i,  // sync reset, active low
  input  wire logic         tick_i,  // sampling enable
  input  wire logic [W-1:0] pins_i,  // raw pin levels
  output logic      [W-1:0] level_o, // sampled level
  output logic      [W-1:0] rise_o,  // rising edge, one cycle
  output logic      [W-1:0] fall_o   // falling edge, one cycle
);

  // two differing samples make an edge, so inputs run at half tick rate
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      level_o <= '0;
      rise_o  <= '0;
      fall_o  <= '0;
    end else if (tick_i) begin
      level_o <= pins_i;
      rise_o  <= pins_i & ~level_o;
      fall_o  <= ~pins_i & level_o;
    end else begin
      rise_o  <= '0;
      fall_o  <= '0;
    end
  end

endmodule

// *** rtl/gtb_core.sv ***
// Operation
// - each timer runs as free timer, gated timer, or external counter
// - both timers count up or down, by software or direction pin
// - timer pin gates in gated mode, gives count edges in counter mode
// - core wrap toggles the latch, latch may drive an output pin
// - auxiliary timer may count toggle latch transitions
// - capture register captures auxiliary or reloads core, or both
// - capture from capture pin or first block count/direction lines
// - core reload from capture register happens on core wrap
// - core wrap event is given out for capture/compare timers
// - cpu write in same cycle beats count, reload or capture
// - core count is live, readable and writable by cpu
// - control bit 15 enables core reload
// - control bit 14 clears core on capture
// - bits 12:11 divide module clock by 4, 2, 16 or 8
// - control bit 10 toggles on core wrap, software writable
// - control bit 9 drives latch on output pin, else high
// - control bit 8 lets direction pin steer the core
// - control bit 7 chooses software direction, 1 is down
// - run bit starts and stops, gated mode also needs gate
// - mode 000 timer, 001 counter, 010 gate low, 011 gate high
// - direction pin high counts down, software bit inverts it
`include "gtb_params.svh"

module gtb_core (
  input  wire logic             clk_i,     // module clock, 10 MHz
  input  wire logic             rstn_i,    // sync reset, active low
  input  wire logic [15:0]      addr_i,    // register address
  input  wire logic             wr_i,      // write strobe
  input  wire logic             rd_i,      // read strobe
  input  wire logic [15:0]      wdata_i,   // write data
  output logic      [15:0]      rdata_o,   // read data, next cycle
  input  wire gtb_pkg::gtb_pins_t pins_i,  // external inputs
  output logic                  toggle_output_pin_o, // latch or high
  output logic                  core_ofl_o // core wrap pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gtb_pkg::gtb_core_ctrl_t ctrl;
  gtb_pkg::gtb_aux_ctrl_t  actl;
  logic [15:0] core_timer;
  logic [15:0] aux_timer;
  logic [15:0] capture_reload_reg;
  logic        shadow;
  logic        tick;
  logic [7:0]  phase;
  gtb_pkg::gtb_pins_t lvl;
  gtb_pkg::gtb_pins_t rise;
  gtb_pkg::gtb_pins_t fall;
  logic        wr_ctrl, wr_actl, wr_core, wr_aux, wr_cap;
  logic        core_dn, aux_dn, core_evt, aux_evt, chain_evt;
  logic        core_wrap, aux_wrap, core_ofl, cap_evt, cap_clr;
  logic [15:0] core_nx, aux_nx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] gtb_step(input logic [15:0] c,
                                           input logic dn);
    if (dn) begin
      return {c == 16'h0000, c - 16'h0001};
    end
    return {c == 16'hffff, c + 16'h0001};
  endfunction

  function automatic logic gtb_evt(input logic [2:0] m,
                                   input logic [2:0] isel,
                                   input logic [7:0] ph,
                                   input logic t,
                                   input logic lv,
                                   input logic r,
                                   input logic f);
    logic pre;
    pre = t && ((ph & ((8'h01 << isel) - 8'h01)) == 8'h00);
    case (m)
      gtb_pkg::MODE_TIMER:   return pre;
      gtb_pkg::MODE_GATE_LO: return pre && !lv;
      gtb_pkg::MODE_GATE_HI: return pre && lv;
      gtb_pkg::MODE_COUNTER: return (isel[0] && r) || (isel[1] && f);
      default:               return 1'b0;
    endcase
  endfunction

  function automatic logic gtb_dir(input logic ude,
                                   input logic ud,
                                   input logic pin);
    return ude ? (pin ^ ud) : ud;
  endfunction

  // ----------------------------------------------------------------
  // clocking and input sampling
  // ----------------------------------------------------------------
  gtb_prescaler u_pre (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .sel_i   (ctrl.block_prescaler_sel),
    .tick_o  (tick),
    .phase_o (phase)
  );

  gtb_sampler #(.W(7)) u_smp (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .tick_i  (tick),
    .pins_i  (pins_i),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_ctrl = wr_i && (addr_i == `GTB_CTRL_ADDR);
  assign wr_actl = wr_i && (addr_i == `GTB_AUXCTL_ADDR);
  assign wr_core = wr_i && (addr_i == `GTB_CORE_ADDR);
  assign wr_aux  = wr_i && (addr_i == `GTB_AUX_ADDR);
  assign wr_cap  = wr_i && (addr_i == `GTB_CAPTURE_RELOAD_REG_ADDR);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == `GTB_CTRL_ADDR) begin
        rdata_o <= ctrl;
      end else if (addr_i == `GTB_AUXCTL_ADDR) begin
        rdata_o <= actl;
      end else if (addr_i == `GTB_CORE_ADDR) begin
        rdata_o <= core_timer;
      end else if (addr_i == `GTB_AUX_ADDR) begin
        rdata_o <= aux_timer;
      end else if (addr_i == `GTB_CAPTURE_RELOAD_REG_ADDR) begin
        rdata_o <= capture_reload_reg;
      end else begin
        rdata_o <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // count events
  // ----------------------------------------------------------------
  assign core_dn = gtb_dir(ctrl.ext_direction_enable,
                           ctrl.sw_direction,
                           lvl.core_dir);
  assign aux_dn  = gtb_dir(actl.ext_direction_enable,
                           actl.sw_direction, lvl.aux_dir);

  assign core_evt = ctrl.run_bit &&
                    gtb_evt(ctrl.mode_field, ctrl.input_select_field,
                            phase, tick, lvl.core_pin,
                            rise.core_pin, fall.core_pin);

  // latch and shadow differ for one cycle after a hardware toggle
  assign chain_evt = (actl.input_select_field[0] &&
                      ctrl.overflow_toggle_latch && !shadow) ||
                     (actl.input_select_field[1] &&
                      !ctrl.overflow_toggle_latch && shadow);

  assign aux_evt = actl.run_bit &&
                   ((actl.chain &&
                     actl.mode_field == gtb_pkg::MODE_COUNTER) ?
                    chain_evt :
                    gtb_evt(actl.mode_field, actl.input_select_field,
                            phase, tick, lvl.aux_pin,
                            rise.aux_pin, fall.aux_pin));

  assign {core_wrap, core_nx} = gtb_step(core_timer, core_dn);
  assign {aux_wrap, aux_nx}   = gtb_step(aux_timer, aux_dn);
  assign core_ofl = core_evt && core_wrap;

  always_comb begin
    case (actl.capture_src)
      gtb_pkg::CAP_RISE: cap_evt = rise.capture_input_pin;
      gtb_pkg::CAP_FALL: cap_evt = fall.capture_input_pin;
      gtb_pkg::CAP_BOTH: cap_evt = rise.capture_input_pin ||
                                   fall.capture_input_pin;
      default:           cap_evt = rise.first_block_count_input ||
                                   fall.first_block_count_input ||
                                   rise.first_block_dir_input ||
                                   fall.first_block_dir_input;
    endcase
    cap_evt = cap_evt && actl.capture_enable;
  end
  assign cap_clr = cap_evt && ctrl.clear_on_capture;

  // ----------------------------------------------------------------
  // timers and capture/reload
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      core_timer <= `GTB_CNT_RST;
    end else if (wr_core) begin
      core_timer <= wdata_i;
    end else if (cap_clr) begin
      core_timer <= 16'h0000;
    end else if (core_ofl && ctrl.reload_enable) begin
      core_timer <= capture_reload_reg;
    end else if (core_evt) begin
      core_timer <= core_nx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aux_timer <= `GTB_CNT_RST;
    end else if (wr_aux) begin
      aux_timer <= wdata_i;
    end else if (cap_evt && actl.aux_clear_on_capture) begin
      aux_timer <= 16'h0000;
    end else if (aux_evt) begin
      aux_timer <= aux_nx;
    end
  end

  // capture and reload may use the register in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      capture_reload_reg <= `GTB_CNT_RST;
    end else if (wr_cap) begin
      capture_reload_reg <= wdata_i;
    end else if (cap_evt) begin
      capture_reload_reg <= aux_timer;
    end
  end

  // ----------------------------------------------------------------
  // control registers and toggle latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl <= `GTB_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= wdata_i & `GTB_CTRL_WMASK;
    end else if (core_ofl) begin
      ctrl.overflow_toggle_latch <= !ctrl.overflow_toggle_latch;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      actl <= `GTB_AUXCTL_RST;
    end else if (wr_actl) begin
      actl <= wdata_i & `GTB_AUXCTL_WMASK;
    end
  end

  // software write moves both latches, so no chain edge is seen
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      shadow <= 1'b0;
    end else if (wr_ctrl) begin
      shadow <= wdata_i[`GTB_OTL_BIT];
    end else begin
      shadow <= ctrl.overflow_toggle_latch;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      toggle_output_pin_o <= 1'b1;
      core_ofl_o          <= 1'b0;
    end else begin
      toggle_output_pin_o <= !ctrl.toggle_output_enable ||
                             ctrl.overflow_toggle_latch;
      core_ofl_o          <= core_ofl;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_cpu_wins;
    wr_core |=> core_timer == $past(wdata_i);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("core write lost");

  property p_wrap_up;
    core_evt && !core_dn && core_timer == 16'hffff && !wr_core &&
    !cap_clr && !ctrl.reload_enable |=> core_timer == 16'h0000 && core_ofl_o;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("up wrap wrong");

  property p_count_dn;
    core_evt && core_dn && core_timer != 16'h0000 && !wr_core && !cap_clr
    |=> core_timer == $past(core_timer) - 16'h0001;
  endproperty
  a_count_dn: assert property (p_count_dn) else $error("down count wrong");

  property p_reload;
    core_ofl && ctrl.reload_enable && !wr_core && !cap_clr
    |=> core_timer == $past(capture_reload_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_toggle;
    core_ofl && !wr_ctrl |=> ctrl.overflow_toggle_latch != $past(ctrl.overflow_toggle_latch)
    ##1 shadow == ctrl.overflow_toggle_latch;
  endproperty
  a_toggle: assert property (p_toggle) else $error("latch not toggled");

  property p_outpin;
    ctrl.toggle_output_enable ##1 ctrl.toggle_output_enable
    |-> toggle_output_pin_o == $past(ctrl.overflow_toggle_latch);
  endproperty
  a_outpin: assert property (p_outpin) else $error("pin not latch");

  property p_capture;
    cap_evt && !wr_cap |=> capture_reload_reg == $past(aux_timer);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_clear;
    cap_clr && !wr_core |=> core_timer == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");

  property p_stopped;
    !ctrl.run_bit && !wr_core && !cap_clr |=> $stable(core_timer);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer moved");

  c_reload: cover property (core_ofl && ctrl.reload_enable);
  c_both:   cover property (core_ofl && ctrl.reload_enable && cap_evt);
  c_chain:  cover property (actl.chain && chain_evt && aux_evt);

endmodule

// *** verification/gtb_cpu_model.sv ***
// ------------------------------------------------------------
// cpu side of the register bus, one access at a time
// ------------------------------------------------------------
module gtb_cpu_model (
  input  wire logic        clk_i,    // module clock
  output logic      [15:0] addr_o,   // register address
  output logic             wr_o,     // write strobe
  output logic             rd_o,     // read strobe
  output logic      [15:0] wdata_o   // write data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr_o  = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 16'h0000;
  end

  // strobe held over one rising edge, then released; gap cycle follows
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask

  task automatic read(input logic [15:0] a);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
  endtask
endmodule

// *** verification/gp_timer_block_core_control_test.sv ***
`include "gtb_params.svh"
`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, act, exp); end end

module gp_timer_block_core_control_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic [15:0]        addr, wdata, rdata_o;
  logic               wr, rd, tog_o, ofl_o, rd_taken;
  gtb_pkg::gtb_pins_t pins;
  logic [15:0]        exp_q[$];
  logic [15:0]        msk_q[$];
  logic [15:0]        v;
  logic [31:0]        seed = 32'h0000_9241;
  int                 errors = 0;
  int                 samples_checked = 0;
  logic [15:0]        mode_tab[5] = '{16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020};
  logic               cnt_tab[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #50 clk_i = ~clk_i;

  gtb_cpu_model u_cpu (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  gtb_core u_dut (
    .clk_i              (clk_i),
    .rstn_i             (rstn_i),
    .addr_i             (addr),
    .wr_i               (wr),
    .rd_i               (rd),
    .wdata_i            (wdata),
    .rdata_o            (rdata_o),
    .pins_i             (pins),
    .toggle_output_pin_o(tog_o),
    .core_ofl_o         (ofl_o)
  );

  // ------------------------------------------------------------
  // read monitor: oldest note against the answer
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    rd_taken <= rd && rstn_i;
  end

  always @(negedge clk_i) begin
    if (rd_taken && exp_q.size() > 0) begin
      `CHECK(rdata_o & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic rd_exp(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_cpu.read(a);
  endtask

  // answer is settled at the negedge where the read task returns
  task automatic rd_get(input logic [15:0] a, output logic [15:0] r);
    rd_exp(a, 16'h0000, 16'h0000);
    r = rdata_o;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wait_ofl();
    int n;
    for (n = 0; n < 400 && ofl_o !== 1'b1; n++) begin
      @(negedge clk_i);
    end
    if (ofl_o !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: no wrap pulse", $time);
      complete_run();
    end
  endtask

  task automatic pin_pulse(input int which);
    repeat (6) @(negedge clk_i);
    if (which == 0) pins.core_pin = 1'b1;
    else if (which == 1) pins.capture_input_pin = ~pins.capture_input_pin;
    else pins.first_block_count_input = ~pins.first_block_count_input;
    repeat (6) @(negedge clk_i);
    if (which == 0) pins.core_pin = 1'b0;
  endtask

  initial begin
    pins = '0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    // reset state, masks, unmapped place
    `CHECK(tog_o, 1'b1)
    rd_exp(`GTB_CTRL_ADDR, `GTB_CTRL_RST, 16'hffff);
    u_cpu.write(`GTB_CTRL_ADDR, 16'hffbf);
    rd_exp(`GTB_CTRL_ADDR, 16'hdfbf, 16'hffff);
    u_cpu.write(16'hfe50, 16'h1234);
    rd_exp(16'hfe50, 16'h0000, 16'hffff);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      u_cpu.write(`GTB_CORE_ADDR, seed[15:0]);
      rd_exp(`GTB_CORE_ADDR, seed[15:0], 16'hffff);
    end
    $display("test registers done");

    // up wrap with reload from capture register
    u_cpu.write(`GTB_CAPTURE_RELOAD_REG_ADDR, 16'h1234);
    u_cpu.write(`GTB_CORE_ADDR, 16'hfff0);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h8840);
    wait_ofl();
    rd_get(`GTB_CORE_ADDR, v);
    `CHECK(v >= 16'h1234 && v < 16'h1240, 1'b1)
    rd_exp(`GTB_CTRL_ADDR, 16'h0400, 16'h0400);
    `CHECK(tog_o, 1'b1)
    $display("test reload done");

    // down wrap without reload, output pin follows latch
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0200);
    u_cpu.write(`GTB_CORE_ADDR, 16'h0003);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h02c0);
    wait_ofl();
    rd_get(`GTB_CORE_ADDR, v);
    `CHECK(v >= 16'hffe0, 1'b1)
    repeat (3) @(negedge clk_i);
    `CHECK(tog_o, 1'b1)
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0200);
    repeat (3) @(negedge clk_i);
    `CHECK(tog_o, 1'b0)
    $display("test underflow done");

    // direction pin against software bit
    for (int i = 0; i < 4; i++) begin
      pins.core_dir = i[1];
      u_cpu.write(`GTB_CORE_ADDR, 16'h0100);
      u_cpu.write(`GTB_CTRL_ADDR, 16'h0940 | (i[0] ? 16'h0080 : 16'h0000));
      repeat (40) @(negedge clk_i);
      u_cpu.write(`GTB_CTRL_ADDR, 16'h0800);
      rd_get(`GTB_CORE_ADDR, v);
      `CHECK(v > 16'h0100, i[1] == i[0])
    end
    pins.core_dir = 1'b0;
    $display("test direction done");

    // modes with the gate pin held low
    for (int i = 0; i < 5; i++) begin
      u_cpu.write(`GTB_CORE_ADDR, 16'h0200);
      u_cpu.write(`GTB_CTRL_ADDR, 16'h0840 | mode_tab[i]);
      repeat (40) @(negedge clk_i);
      u_cpu.write(`GTB_CTRL_ADDR, 16'h0800);
      rd_get(`GTB_CORE_ADDR, v);
      `CHECK(v != 16'h0200, cnt_tab[i])
    end
    $display("test modes done");

    // counter mode on rising edges
    u_cpu.write(`GTB_CORE_ADDR, 16'h0300);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0849);
    for (int i = 0; i < 5; i++) pin_pulse(0);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0800);
    rd_exp(`GTB_CORE_ADDR, 16'h0305, 16'hffff);
    $display("test counter done");

    // capture from pin and from first block line, clear on capture
    u_cpu.write(`GTB_AUX_ADDR, 16'h5555);
    u_cpu.write(`GTB_CORE_ADDR, 16'h0777);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h4800);
    u_cpu.write(`GTB_AUXCTL_ADDR, 16'h1000);
    pin_pulse(1);
    rd_exp(`GTB_CAPTURE_RELOAD_REG_ADDR, 16'h5555, 16'hffff);
    rd_exp(`GTB_CORE_ADDR, 16'h0000, 16'hffff);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0800);
    u_cpu.write(`GTB_CORE_ADDR, 16'h0777);
    u_cpu.write(`GTB_AUX_ADDR, 16'h6666);
    u_cpu.write(`GTB_AUXCTL_ADDR, 16'h1c00);
    pin_pulse(2);
    rd_exp(`GTB_CAPTURE_RELOAD_REG_ADDR, 16'h6666, 16'hffff);
    rd_exp(`GTB_CORE_ADDR, 16'h0777, 16'hffff);
    u_cpu.write(`GTB_AUX_ADDR, 16'h7777);
    u_cpu.write(`GTB_AUXCTL_ADDR, 16'h1400);
    pin_pulse(1);
    rd_exp(`GTB_CAPTURE_RELOAD_REG_ADDR, 16'h7777, 16'hffff);
    $display("test capture done");

    // chained auxiliary timer takes one latch rise, counting down
    u_cpu.write(`GTB_AUX_ADDR, 16'h0010);
    u_cpu.write(`GTB_CORE_ADDR, 16'hfffe);
    u_cpu.write(`GTB_AUXCTL_ADDR, 16'h02c9);
    u_cpu.write(`GTB_CTRL_ADDR, 16'h1040);
    wait_ofl();
    // write lands while the core is running
    u_cpu.write(`GTB_CORE_ADDR, 16'h4000);
    rd_get(`GTB_CORE_ADDR, v);
    `CHECK(v >= 16'h4000 && v < 16'h4002, 1'b1)
    u_cpu.write(`GTB_CTRL_ADDR, 16'h0000);
    u_cpu.write(`GTB_AUXCTL_ADDR, 16'h0000);
    rd_exp(`GTB_AUX_ADDR, 16'h000f, 16'hffff);
    $display("test chain done");

    repeat (4) @(negedge clk_i);
    `CHECK(exp_q.size(), 0)
    complete_run();
  end
endmodule
